// >>> logic/wwdt_core.sv
// window watchdog timing core: strap capture, trigger sync, window check
`default_nettype none
module wwdt_core #(
    parameter int unsigned RST_PULSE_CYC = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_watchdog_trigger_in,
    input wire logic [1:0] i_timeout_select_pin,
    input wire logic i_ratio_select_pin,
    input wire logic [31:0] i_cap_ff,
    output logic o_reset,
    output logic o_early_fault,
    output logic o_late_fault
);
    // ************************************************
    // synchronisers
    // ************************************************
    logic [1:0] trig_sync_q;
    logic trig_prev_q;
    logic [1:0] tsel_m_q;
    logic [1:0] tsel_s_q;
    logic [1:0] rsel_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            trig_sync_q <= 2'h0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[0], i_watchdog_trigger_in};
            trig_prev_q <= trig_sync_q[1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tsel_m_q <= wwdt_pkg::RST_SYNC;
            tsel_s_q <= wwdt_pkg::RST_SYNC;
            rsel_q <= wwdt_pkg::RST_SYNC;
        end else begin
            tsel_m_q <= i_timeout_select_pin;
            tsel_s_q <= tsel_m_q;
            rsel_q <= {rsel_q[0], i_ratio_select_pin};
        end
    end

    logic trig_rise;
    assign trig_rise = trig_sync_q[1] & ~trig_prev_q;

    // ************************************************
    // strap capture after reset release
    // ************************************************
    wwdt_pkg::wwdt_cfg_t cfg_q;
    logic [1:0] cap_cnt_q;
    logic cfg_ok_q;
    logic cap_done;

    // unused code 3 falls back to the short strapped window
    function automatic wwdt_pkg::wwdt_tsel_t tsel_decode(input logic [1:0] code);
        unique case (code)
            2'h1: tsel_decode = wwdt_pkg::WWDT_TSEL_HIGH;
            2'h2: tsel_decode = wwdt_pkg::WWDT_TSEL_CAP;
            default: tsel_decode = wwdt_pkg::WWDT_TSEL_LOW;
        endcase
    endfunction

    assign cap_done = cap_cnt_q == 2'h3;

    // straps are static; wait for the synchroniser to fill before latching
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cap_cnt_q <= 2'h0;
        end else if (!cfg_ok_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg_ok_q <= 1'b0;
        end else if (cap_done) begin
            cfg_ok_q <= 1'b1;
        end
    end

    // latched once: a strap change needs a supervisor reset to take effect
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg_q <= '0;
        end else if (cap_done && !cfg_ok_q) begin
            cfg_q.tsel <= tsel_decode(tsel_s_q);
            cfg_q.ratio_fine <= rsel_q[1];
        end
    end

    wwdt_pkg::wwdt_limits_t lim;

    wwdt_limits u_limits (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_cfg(cfg_q),
        .i_cap_ff(i_cap_ff),
        .o_lim(lim)
    );

    // ************************************************
    // window timer
    // ************************************************
    typedef enum logic [2:0] {
        WWDT_ST_SETUP = 3'h1,
        WWDT_ST_RUN = 3'h2,
        WWDT_ST_RESET = 3'h4
    } wwdt_state_t;

    wwdt_state_t state_q;
    logic [wwdt_pkg::CNT_W-1:0] tmr_q;
    logic [15:0] rst_cnt_q;
    logic armed_q;
    logic early;
    logic late;
    logic fault;
    logic pulse_end;

    // edges inside the tolerance bands are left to the servicing side
    assign early = trig_rise && armed_q && (tmr_q < lim.boundary);
    assign late = !trig_rise && (tmr_q >= lim.window - 32'h1);
    assign fault = (state_q == WWDT_ST_RUN) && (early || late);
    assign pulse_end = rst_cnt_q == 16'(RST_PULSE_CYC - 1);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= WWDT_ST_SETUP;
        end else begin
            unique case (state_q)
                WWDT_ST_SETUP: begin
                    if (cfg_ok_q && lim.window != '0) begin
                        state_q <= WWDT_ST_RUN;
                    end
                end
                WWDT_ST_RUN: begin
                    if (fault) begin
                        state_q <= WWDT_ST_RESET;
                    end
                end
                WWDT_ST_RESET: begin
                    if (pulse_end) begin
                        state_q <= WWDT_ST_RUN;
                    end
                end
            endcase
        end
    end

    // timer held at zero outside the run state, restarted by every edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tmr_q <= '0;
        end else if (state_q != WWDT_ST_RUN || fault || trig_rise) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
        end
    end

    // lower boundary only after the first accepted edge of a run
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            armed_q <= 1'b0;
        end else if (state_q != WWDT_ST_RUN || fault) begin
            armed_q <= 1'b0;
        end else if (trig_rise) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_cnt_q <= 16'h0;
        end else if (state_q == WWDT_ST_RESET) begin
            rst_cnt_q <= rst_cnt_q + 16'h1;
        end else begin
            rst_cnt_q <= 16'h0;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_reset <= 1'b0;
        end else begin
            o_reset <= fault || (state_q == WWDT_ST_RESET && !pulse_end);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_early_fault <= 1'b0;
        end else begin
            o_early_fault <= state_q == WWDT_ST_RUN && early;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_late_fault <= 1'b0;
        end else begin
            o_late_fault <= state_q == WWDT_ST_RUN && late;
        end
    end
endmodule
`default_nettype wire

// >>> logic/wwdt_limits.sv
// limit table: window and lower boundary cycle counts from the straps
`default_nettype none
module wwdt_limits (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire wwdt_pkg::wwdt_cfg_t i_cfg,
    input wire logic [31:0] i_cap_ff,
    output wwdt_pkg::wwdt_limits_t o_lim
);
    function automatic logic [31:0] divx10(input logic [63:0] w, input int unsigned r);
        divx10 = 32'((w * 64'd10 + 64'(r) - 64'd1) / 64'(r));
    endfunction

    function automatic logic [31:0] pct(input logic [63:0] w, input int unsigned p);
        pct = 32'((w * 64'(p)) / 64'd100);
    endfunction

    logic [63:0] cap_typ;
    logic [63:0] cap_min;
    logic [63:0] cap_max;
    wwdt_pkg::wwdt_limits_t lim_d;

    always_comb begin
        // window typ = base * (1 + c/unit); the guarded edges judge min window, max boundary
        cap_typ = 64'(wwdt_pkg::CAP_BASE_CYC)
            + (64'(wwdt_pkg::CAP_BASE_CYC) * 64'(i_cap_ff)) / 64'(wwdt_pkg::CAP_UNIT_FF);
        cap_min = 64'(pct(cap_typ, wwdt_pkg::CAP_MIN_PCT));
        cap_max = 64'(pct(cap_typ, wwdt_pkg::CAP_MAX_PCT));
        lim_d = '0;
        unique case (i_cfg.tsel)
            wwdt_pkg::WWDT_TSEL_LOW: begin
                lim_d.window = wwdt_pkg::WIN_LOW_CYC;
                lim_d.boundary = i_cfg.ratio_fine ?
                    divx10(64'(wwdt_pkg::WIN_LOW_CYC), wwdt_pkg::RAT_LOW_FINE) :
                    divx10(64'(wwdt_pkg::WIN_LOW_CYC), wwdt_pkg::RAT_LOW_COARSE);
            end
            wwdt_pkg::WWDT_TSEL_HIGH: begin
                lim_d.window = wwdt_pkg::WIN_HIGH_CYC;
                lim_d.boundary = i_cfg.ratio_fine ?
                    divx10(64'(wwdt_pkg::WIN_HIGH_CYC), wwdt_pkg::RAT_HIGH_FINE) :
                    divx10(64'(wwdt_pkg::WIN_HIGH_CYC), wwdt_pkg::RAT_HIGH_COARSE);
            end
            default: begin
                // capacitor sets the window; check against worst-case edges
                lim_d.window = 32'(cap_min);
                lim_d.boundary = i_cfg.ratio_fine ?
                    divx10(cap_max, wwdt_pkg::CAP_BMAX_FINE) :
                    divx10(cap_max, wwdt_pkg::CAP_BMAX_COARSE);
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_lim <= '0;
        end else begin
            o_lim <= lim_d;
        end
    end
endmodule
`default_nettype wire

// >>> logic/wwdt_pkg.sv
// package: constants and types for the window watchdog timing block
`default_nettype none
package wwdt_pkg;
    // ********************************************
    // clock and timing
    // ********************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned WIN_LOW_US = 250_000;
    localparam int unsigned WIN_HIGH_US = 2_500_000;
    localparam int unsigned CAP_BASE_US = 6_250;
    localparam int unsigned CAP_UNIT_FF = 15_550;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned CNT_W = 32;
    localparam logic [CNT_W-1:0] WIN_LOW_CYC = CNT_W'(64'(WIN_LOW_US) * CYC_PER_US);
    localparam logic [CNT_W-1:0] WIN_HIGH_CYC = CNT_W'(64'(WIN_HIGH_US) * CYC_PER_US);
    localparam logic [CNT_W-1:0] CAP_BASE_CYC = CNT_W'(64'(CAP_BASE_US) * CYC_PER_US);
    // ratios kept in tenths: lower boundary = window * 10 / ratio_x10
    localparam int unsigned RAT_LOW_FINE = 1249;
    localparam int unsigned RAT_HIGH_FINE = 1277;
    localparam int unsigned RAT_CAP_FINE = 645;
    localparam int unsigned RAT_LOW_COARSE = 318;
    localparam int unsigned RAT_HIGH_COARSE = 320;
    localparam int unsigned RAT_CAP_COARSE = 258;
    // capacitor tolerance in percent, capacitor boundary ratios in tenths
    localparam int unsigned CAP_MAX_PCT = 125;
    localparam int unsigned CAP_MIN_PCT = 75;
    localparam int unsigned CAP_BMAX_FINE = 516;
    localparam int unsigned CAP_BMIN_FINE = 927;
    localparam int unsigned CAP_BMAX_COARSE = 235;
    localparam int unsigned CAP_BMIN_COARSE = 287;
    localparam logic [1:0] RST_SYNC = 2'h0;

    // ********************************************
    // types
    // ********************************************
    typedef enum logic [1:0] {
        WWDT_TSEL_LOW = 2'h0,
        WWDT_TSEL_HIGH = 2'h1,
        WWDT_TSEL_CAP = 2'h2
    } wwdt_tsel_t;

    typedef struct packed {
        wwdt_tsel_t tsel;
        logic ratio_fine;
    } wwdt_cfg_t;

    typedef struct packed {
        logic [CNT_W-1:0] window;
        logic [CNT_W-1:0] boundary;
    } wwdt_limits_t;
endpackage
`default_nettype wire

// >>> tb/wwdt_core_test.sv
// testbench: window watchdog core in capacitor mode
`default_nettype none
module wwdt_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // model limits
    // ****************************************
    localparam int PULSE = 12;
    localparam int WIN = wwdt_pkg::CAP_BASE_CYC * wwdt_pkg::CAP_MIN_PCT / 100;
    localparam int BND = (wwdt_pkg::CAP_BASE_CYC * 125 / 10 + 515) / 516;
    localparam int BNDC = (wwdt_pkg::CAP_BASE_CYC * 125 / 10 + 234) / 235;
    logic rsel = 1'b1;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic fire = 1'b0;
    logic [31:0] gap = 32'h0;
    logic trig;
    logic o_reset;
    logic o_early_fault;
    logic o_late_fault;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'h6dd424d8;
    int n = 0;
    bit armed = 0;
    wwdt_host u_host (.i_clk(i_clk), .i_fire(fire), .i_gap(gap), .o_trig(trig));
    wwdt_core #(.RST_PULSE_CYC(PULSE)) u_dut (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_watchdog_trigger_in(trig),
        .i_timeout_select_pin(wwdt_pkg::WWDT_TSEL_CAP),
        .i_ratio_select_pin(rsel),
        .i_cap_ff(32'h0),
        .o_reset(o_reset),
        .o_early_fault(o_early_fault),
        .o_late_fault(o_late_fault)
    );
    initial forever #25 i_clk = ~i_clk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one trigger g cycles after request; model predicts the verdict
    task automatic serve(input int g, input int bnd);
        int e = 0;
        int l = 0;
        int r = 0;
        bit exp_e;
        // edges are g + 32 cycles apart, so the timer shows g + 31 at the edge
        exp_e = armed && (g + 31 < bnd);
        @(posedge i_clk) #2 gap = 32'(g);
        fire = 1'b1;
        @(posedge i_clk) #2 fire = 1'b0;
        repeat (g + 30) begin
            @(posedge i_clk) #1;
            e += int'(o_early_fault === 1'b1);
            l += int'(o_late_fault === 1'b1);
            r += int'(o_reset === 1'b1);
        end
        check("early fault", 32'(exp_e), 32'(e));
        check("late fault", 32'h0, 32'(l));
        check("reset cycles", exp_e ? PULSE : 0, 32'(r));
        armed = !exp_e;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 110000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        #2 i_srst = 1'b0;
        repeat (20) @(posedge i_clk);
        serve(300, BND);
        serve(3100 + ($random(seed) & 511), BND);
        serve(500 + ($random(seed) & 511), BND);
        while (o_late_fault !== 1'b1 && n < WIN + 100) begin
            @(posedge i_clk) #1;
            n++;
        end
        check("late timing", 32'h1, 32'(n >= WIN - 40 && n <= WIN + 8));
        // second run with the coarse ratio: a gap from the same range is now too early
        @(posedge i_clk) #2 i_srst = 1'b1;
        rsel = 1'b0;
        armed = 0;
        repeat (3) @(posedge i_clk);
        #2 i_srst = 1'b0;
        repeat (20) @(posedge i_clk);
        serve(300, BNDC);
        serve(3100 + ($random(seed) & 511), BNDC);
        conclude();
    end
endmodule
`default_nettype wire

// >>> tb/wwdt_host.sv
// host model: raises the trigger a set number of cycles after a request
`default_nettype none
module wwdt_host (
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic [31:0] i_gap,
    output logic o_trig
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    initial o_trig = 1'b0;
    // high for 8 cycles so the edge survives any clock phase
    always @(posedge i_clk) begin
        if (i_fire) begin
            cnt = int'(i_gap) + 8;
        end else if (cnt > 0) begin
            cnt = cnt - 1;
        end
        #2 o_trig = cnt > 0 && cnt <= 8;
    end
endmodule
`default_nettype wire

// >>> tb/wwdt_monitor.sv
// checker: output timing of the window watchdog core
`default_nettype none
module wwdt_monitor #(
    parameter int unsigned RST_PULSE_CYC = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_watchdog_trigger_in,
    input wire logic o_reset,
    input wire logic o_early_fault,
    input wire logic o_late_fault
);
    logic [7:0] hist_q;
    logic [31:0] len_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    always_ff @(posedge i_clk) begin
        hist_q <= {hist_q[6:0], i_watchdog_trigger_in};
    end
    always_ff @(posedge i_clk) begin
        len_q <= (i_srst || !o_reset) ? 32'h0 : len_q + 32'h1;
    end
    a_early_resets: assert property (o_early_fault |-> o_reset)
        else $error("early fault without reset");
    a_late_resets: assert property (o_late_fault |-> o_reset)
        else $error("late fault without reset");
    a_reset_cause: assert property ($rose(o_reset) |-> o_early_fault || o_late_fault)
        else $error("reset without fault");
    a_early_single: assert property (o_early_fault |=> !o_early_fault)
        else $error("early fault too long");
    a_late_single: assert property (o_late_fault |=> !o_late_fault)
        else $error("late fault too long");
    a_pulse_len: assert property ($fell(o_reset) |-> len_q == RST_PULSE_CYC)
        else $error("reset pulse length");
    a_quiet_release: assert property ($fell(i_srst) |-> !o_reset && !o_early_fault)
        else $error("output active after release");
    // early fault must follow a recent trigger edge
    a_edge_cause: assert property (o_early_fault |-> (hist_q[6:1] & ~hist_q[7:2]) != 6'h0)
        else $error("early fault without edge");
endmodule
bind wwdt_core wwdt_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_mon (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_watchdog_trigger_in(i_watchdog_trigger_in),
    .o_reset(o_reset),
    .o_early_fault(o_early_fault),
    .o_late_fault(o_late_fault)
);
`default_nettype wire
